// ==== rtl/output_router_pkg.sv ====
// Package: register map, field layout, reset values and types for the status output router
package output_router_pkg;

  // Register indices (word addresses on the plain register port)
  localparam logic [3:0] addr_select_a = 4'h0;
  localparam logic [3:0] addr_select_b = 4'h1;
  localparam logic [3:0] addr_select_c = 4'h2;
  localparam logic [3:0] addr_inversion = 4'h3;
  localparam logic [3:0] addr_mode = 4'h4;
  localparam logic [3:0] addr_status = 4'h5;

  // Field layout: each selection field is one nibble
  localparam int field_width = 4;
  localparam int fields_per_reg = 4;
  localparam int num_signals = 10;
  localparam int num_circuits = 3;

  // Selection codes
  localparam logic [3:0] sel_none = 4'h0;
  localparam logic [3:0] sel_circuit_one = 4'h1;
  localparam logic [3:0] sel_circuit_two = 4'h2;
  localparam logic [3:0] sel_circuit_three = 4'h3;

  // Reset values
  localparam logic [15:0] select_a_reset = 16'h3211;
  localparam logic [15:0] select_b_reset = 16'h0000;
  localparam logic [15:0] select_c_reset = 16'h0000;
  localparam logic [15:0] inversion_reset = 16'h0000;
  localparam logic [1:0] mode_reset = 2'h0;

  // Writable bits of the sparse registers
  localparam logic [15:0] select_c_mask = 16'h00ff;
  localparam logic [15:0] inversion_mask = 16'h0007;

  // Control modes; only speed mode lacks a position loop
  typedef enum logic [1:0] {
    mode_position = 2'b00,
    mode_speed = 2'b01,
    mode_torque = 2'b10
  } control_mode_t;

  // Raw status signals from the drive core
  typedef struct packed {
    logic positioning_complete;
    logic speed_coincidence;
    logic rotation_detected;
    logic servo_ready;
    logic torque_limit_detected;
    logic speed_limit_detected;
    logic brake_interlock;
    logic overload;
    logic regen_overload;
    logic approach_window_flag;
  } status_in_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : output_router_pkg

// ==== rtl/servo_output_signal_router.sv ====
// Module: routes drive status signals onto three sequence output circuits
`timescale 1ns/1ps
`default_nettype none

module servo_output_signal_router (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic reset, // Asynchronous reset, active high
  input wire output_router_pkg::reg_req_t reg_req, // Register port request
  output logic [15:0] reg_rdata, // Read data, one cycle after read strobe
  input wire output_router_pkg::status_in_t status_in, // Status signals from drive core
  output logic [2:0] output_circuits // Bit 0 circuit one .. bit 2 circuit three
);

  // Register map seen by software on the plain port:
  //   index 0  selection word a
  //   index 1  selection word b
  //   index 2  selection word c, upper byte reads zero
  //   index 3  inversion word, one bit per output circuit
  //   index 4  control mode, reserved code folds to position
  //   index 5  output circuit levels, read only
  // Field order across the words, lowest field first:
  //   0 positioning complete    1 speed coincidence
  //   2 rotation detected       3 servo ready
  //   4 torque limit detected   5 speed limit detected
  //   6 brake interlock         7 warning
  //   8 approach window flag    9 reserved
  // Timing: a write lands at the next edge and the pins follow one edge
  // later, so a reconfiguration shows on the circuits two edges after the
  // strobe. Status inputs share this clock and are not synchronised; a
  // caller feeding them from another clock must synchronise first.

  // Decode one selection field against a circuit code; codes 4..f never match
  function automatic logic routes_to(input logic [3:0] code, input logic [3:0] circuit);
    routes_to = (code == circuit);
  endfunction : routes_to

  // Write strobe aimed at one register index
  function automatic logic write_hit(input output_router_pkg::reg_req_t req,
                                     input logic [3:0] index);
    write_hit = req.wr && (req.addr == index);
  endfunction : write_hit

  // Read strobe aimed at one register index
  function automatic logic read_hit(input output_router_pkg::reg_req_t req,
                                    input logic [3:0] index);
    read_hit = req.rd && (req.addr == index);
  endfunction : read_hit

  // Whether a slot is detectable in the given mode. Only the positioning
  // result depends on the mode: speed control has no position loop
  function automatic logic detectable(input output_router_pkg::control_mode_t mode,
                                      input int slot);
    detectable = 1'b1;
    case (mode)
      output_router_pkg::mode_position: begin
        detectable = 1'b1;
      end
      output_router_pkg::mode_speed: begin
        detectable = (slot != 0);
      end
      output_router_pkg::mode_torque: begin
        detectable = 1'b1;
      end
      default: begin
        detectable = 1'b1;
      end
    endcase
  endfunction : detectable

  // Selection words: signal i is steered by field i across the three words
  logic [15:0] select_a_reg;
  logic [15:0] select_a_next;
  logic [15:0] select_b_reg;
  logic [15:0] select_b_next;
  logic [15:0] select_c_reg;
  logic [15:0] select_c_next;

  // Inversion word; only the low three bits hold state
  logic [15:0] inversion_reg;
  logic [15:0] inversion_next;

  // Active control mode
  output_router_pkg::control_mode_t mode_reg;
  output_router_pkg::control_mode_t mode_next;

  // Read data, zero outside the answer cycle
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Output circuit levels after inversion
  logic [2:0] circuits_reg;
  logic [2:0] circuits_next;

  // Routing network between the status inputs and the output registers
  logic [output_router_pkg::num_signals-1:0] raw;
  logic [output_router_pkg::num_signals-1:0] gated;
  logic [output_router_pkg::num_signals*output_router_pkg::field_width-1:0] codes;
  logic [output_router_pkg::num_circuits-1:0] ored;
  logic warning;

  // Selection word a next value
  always_comb begin
    select_a_next = select_a_reg;
    if (write_hit(reg_req, output_router_pkg::addr_select_a)) begin
      select_a_next = reg_req.wdata;
    end
  end

  // Selection word a; reset routes positioning and speed to circuit one,
  // rotation to circuit two and ready to circuit three
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      select_a_reg <= output_router_pkg::select_a_reset;
    end else begin
      select_a_reg <= select_a_next;
    end
  end

  // Selection word b next value
  always_comb begin
    select_b_next = select_b_reg;
    if (write_hit(reg_req, output_router_pkg::addr_select_b)) begin
      select_b_next = reg_req.wdata;
    end
  end

  // Selection word b; reset leaves limits, brake and warning unrouted
  // so a fresh drive never raises an unexpected terminal
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      select_b_reg <= output_router_pkg::select_b_reset;
    end else begin
      select_b_reg <= select_b_next;
    end
  end

  // Selection word c next value; its upper byte has no fields
  always_comb begin
    select_c_next = select_c_reg;
    if (write_hit(reg_req, output_router_pkg::addr_select_c)) begin
      select_c_next = reg_req.wdata & output_router_pkg::select_c_mask;
    end
  end

  // Selection word c; reset leaves the window flag unrouted
  // and the unused upper byte at zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      select_c_reg <= output_router_pkg::select_c_reset;
    end else begin
      select_c_reg <= select_c_next;
    end
  end

  // Inversion next value; bits above circuit three are not stored,
  // so they always read back as zero
  always_comb begin
    inversion_next = inversion_reg;
    if (write_hit(reg_req, output_router_pkg::addr_inversion)) begin
      inversion_next = reg_req.wdata & output_router_pkg::inversion_mask;
    end
  end

  // Inversion word; reset leaves every circuit not inverted
  // so the pins start at their plain OFF level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      inversion_reg <= output_router_pkg::inversion_reset;
    end else begin
      inversion_reg <= inversion_next;
    end
  end

  // Mode next value; the reserved code folds to position so the
  // gating below never sees an undecoded mode
  always_comb begin
    mode_next = mode_reg;
    if (write_hit(reg_req, output_router_pkg::addr_mode)) begin
      if (reg_req.wdata[1:0] == 2'h3) begin
        mode_next = output_router_pkg::mode_position;
      end else begin
        mode_next = output_router_pkg::control_mode_t'(reg_req.wdata[1:0]);
      end
    end
  end

  // Control mode register; reset starts in position control
  // where every slot is detectable
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_reg <= output_router_pkg::control_mode_t'(output_router_pkg::mode_reset);
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Read mux; unmapped indices and idle cycles give zero, so the data
  // stand only in the cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (read_hit(reg_req, output_router_pkg::addr_select_a)) begin
      rdata_next = select_a_reg;
    end else if (read_hit(reg_req, output_router_pkg::addr_select_b)) begin
      rdata_next = select_b_reg;
    end else if (read_hit(reg_req, output_router_pkg::addr_select_c)) begin
      rdata_next = select_c_reg;
    end else if (read_hit(reg_req, output_router_pkg::addr_inversion)) begin
      rdata_next = inversion_reg;
    end else if (read_hit(reg_req, output_router_pkg::addr_mode)) begin
      rdata_next = {14'h0000, mode_reg};
    end else if (read_hit(reg_req, output_router_pkg::addr_status)) begin
      rdata_next = {13'h0000, circuits_reg};
    end
  end

  // Read data register; a registered answer keeps the read path
  // out of the address decode timing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Status signals in field order; the warning slot merges both
  // overload sources so either one can raise it
  always_comb begin
    warning = status_in.overload | status_in.regen_overload;
    raw = '0;
    // Motion results
    raw[0] = status_in.positioning_complete;
    raw[1] = status_in.speed_coincidence;
    raw[2] = status_in.rotation_detected;
    raw[3] = status_in.servo_ready;
    // Limits and brake
    raw[4] = status_in.torque_limit_detected;
    raw[5] = status_in.speed_limit_detected;
    raw[6] = status_in.brake_interlock;
    // Warning and window
    raw[7] = warning;
    raw[8] = status_in.approach_window_flag;
    raw[9] = 1'b0; // Reserved slot never carries a signal
  end

  // Mode gating, one cell per slot; an undetectable signal is forced OFF
  // before routing so it can never leak through an OR tree, whichever
  // circuit its field points at
  for (genvar s = 0; s < output_router_pkg::num_signals; s++) begin : g_gate
    assign gated[s] = raw[s] & detectable(mode_reg, s);
  end

  // Flattened selection codes, signal i in field i; the upper byte
  // of word c carries no field and is left out
  assign codes = {select_c_reg[7:0], select_b_reg, select_a_reg};

  // One OR tree per output circuit; each tree scans every field for its
  // own code, so several signals on one circuit simply combine and a
  // signal whose field holds 0 or an unused code joins no tree
  for (genvar c = 0; c < output_router_pkg::num_circuits; c++) begin : g_circuit
    localparam logic [3:0] circuit_code = 4'(c + 1);
    logic any_routed;

    always_comb begin
      any_routed = 1'b0;
      for (int s = 0; s < output_router_pkg::num_signals; s++) begin
        if (routes_to(codes[s*output_router_pkg::field_width +: 4], circuit_code)) begin
          any_routed = any_routed | gated[s];
        end
      end
    end

    assign ored[c] = any_routed;
  end

  // Inversion acts on the combined result, so an empty circuit shows
  // its inversion bit alone
  always_comb begin
    circuits_next = ored ^ inversion_reg[2:0];
  end

  // Output circuits are registered so the pins never carry decode glitches;
  // the price is one cycle of latency behind the status inputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      circuits_reg <= 3'h0;
    end else begin
      circuits_reg <= circuits_next;
    end
  end

  // Port drivers
  assign reg_rdata = rdata_reg;
  assign output_circuits = circuits_reg;

endmodule : servo_output_signal_router

`default_nettype wire

// ==== tb/router_checker_assertions.sv ====
// Checker: port-level properties of the status output router
`timescale 1ns/1ps
`default_nettype none
module router_checker (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset
  input wire output_router_pkg::reg_req_t reg_req, // Register request
  input wire logic [15:0] reg_rdata, // Read data
  input wire output_router_pkg::status_in_t status_in, // Status inputs
  input wire logic [2:0] output_circuits // Output circuits
);
  logic [2:0] inv_reg;
  logic [1:0] mode_reg;
  // Shadow of inversion and mode; mode code 3 is stored as 0
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) begin
      inv_reg <= 3'h0;
      mode_reg <= 2'h0;
    end else if (reg_req.wr && reg_req.addr == 4'h3) inv_reg <= reg_req.wdata[2:0];
    else if (reg_req.wr && reg_req.addr == 4'h4)
      mode_reg <= (reg_req.wdata[1:0] == 2'h3) ? 2'h0 : reg_req.wdata[1:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_quiet; $stable(status_in) && !reg_req.wr; endsequence
  sequence s_inv_wr; reg_req.wr && reg_req.addr == 4'h3; endsequence
  sequence s_inv_rd; reg_req.rd && reg_req.addr == 4'h3; endsequence
  property p_idle; status_in == '0 && !reg_req.wr |=> output_circuits == inv_reg; endproperty
  a_idle: assert property (p_idle) else $error("empty circuit level");
  property p_gate;
    mode_reg == 2'h1 && status_in == 10'h200 && !reg_req.wr |=> output_circuits == inv_reg;
  endproperty
  a_gate: assert property (p_gate) else $error("positioning not gated");
  property p_inv; s_inv_wr ##1 s_inv_rd |=> reg_rdata == {13'h0, $past(reg_req.wdata[2:0], 2)};
  endproperty
  a_inv: assert property (p_inv) else $error("inversion readback");
  property p_stat; reg_req.rd && reg_req.addr == 4'h5 |=> reg_rdata == {13'h0, $past(output_circuits)};
  endproperty
  a_stat: assert property (p_stat) else $error("status readback");
  property p_hold; s_quiet ##1 s_quiet |=> $stable(output_circuits); endproperty
  a_hold: assert property (p_hold) else $error("output moved unprompted");
  property p_rdc; reg_req.rd && reg_req.addr == 4'h2 |=> reg_rdata[15:8] == 8'h0; endproperty
  a_rdc: assert property (p_rdc) else $error("select c upper bits");
  property p_mode; reg_req.rd && reg_req.addr == 4'h4 |=> reg_rdata == {14'h0, mode_reg}; endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_unmap; reg_req.rd && reg_req.addr > 4'h5 |=> reg_rdata == 16'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule : router_checker
bind servo_output_signal_router router_checker router_checker_i (.clk_sys, .reset, .reg_req,
  .reg_rdata, .status_in, .output_circuits);
`default_nettype wire

// ==== tb/host_terminal_model.sv ====
// Host model: samples the three output terminals each clock
`timescale 1ns/1ps
`default_nettype none
module host_terminal_model (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset
  input wire logic [2:0] output_circuits, // Terminal levels
  output logic [2:0] terminals_seen // Levels latched by host
);
  // Host input register, so the bench sees settled levels only
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) terminals_seen <= 3'h0;
    else terminals_seen <= output_circuits;
endmodule : host_terminal_model
`default_nettype wire

// ==== tb/servo_output_signal_router_tb_top.sv ====
// Testbench: random routing setups against a reference model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module servo_output_signal_router_tb_top;
  logic clk_sys = 0;
  logic reset = 1;
  output_router_pkg::reg_req_t reg_req = '0;
  output_router_pkg::status_in_t status_in = '0;
  logic [15:0] reg_rdata, sa, sb, sc, inv;
  logic [2:0] output_circuits, terminals_seen;
  logic [31:0] lfsr = 32'd92518;
  logic [1:0] md;
  logic [9:0] st;
  int failures = 0, samples_checked = 0, cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  servo_output_signal_router servo_output_signal_router_i (.clk_sys, .reset, .reg_req,
    .reg_rdata, .status_in, .output_circuits);
  host_terminal_model host_terminal_model_i (.clk_sys, .reset, .output_circuits, .terminals_seen);
  function automatic logic [31:0] rnd(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : rnd
  // Reference: gate by mode, route by nibble, OR, then invert
  function automatic logic [2:0] model(input logic [9:0] s);
    logic [39:0] cfg;
    logic [9:0] sig;
    logic [2:0] o;
    cfg = {sc[7:0], sb, sa};
    sig = {1'b0, s[0], s[2] | s[1], s[3], s[4], s[5], s[6], s[7], s[8], s[9] & (md != 2'h1)};
    o = 3'h0;
    for (int k = 0; k < 10; k++)
      for (int c = 1; c < 4; c++)
        if (sig[k] && cfg[4*k +: 4] == c) o[c-1] = 1'b1;
    return o ^ inv[2:0];
  endfunction : model
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    reg_req <= '0;
    #1 `CHK(reg_rdata, e)
    @(posedge clk_sys);
  endtask : rd
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, 16'h3211);
    rd(4'h1, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(4'h9, 16'h0000);
    wr(4'h4, 16'h0003);
    rd(4'h4, 16'h0000);
    $display("reset test done");
    // Early passes hold only positioning complete, one of them in speed mode
    for (int n = 0; n < 100; n++) begin
      lfsr = rnd(lfsr);
      sa = lfsr[15:0];
      sb = lfsr[31:16];
      lfsr = rnd(lfsr);
      sc = lfsr[15:0];
      inv = lfsr[31:16];
      md = 2'(n % 3);
      st = (n < 3) ? 10'h200 : lfsr[29:20];
      wr(4'h0, sa);
      wr(4'h1, sb);
      wr(4'h2, sc);
      wr(4'h4, {14'h0, md});
      wr(4'h3, inv);
      rd(4'h3, inv & 16'h0007);
      rd(4'h2, sc & 16'h00ff);
      rd(4'h4, {14'h0, md});
      status_in <= st;
      repeat (2) @(posedge clk_sys);
      #1 `CHK(terminals_seen, model(st))
      @(posedge clk_sys);
      rd(4'h5, {13'h0, model(st)});
    end
    $display("random routing test done");
    complete_run;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
endmodule : servo_output_signal_router_tb_top
`default_nettype wire
